// file: core/contact_hold_pkg.sv
// Purpose: shared constants, encodings and carrier types of the contact-hold mode control
// Assumes: 16-bit parameter words; frequencies in 0.01 Hz steps, levels in whole percent
// Notes:   the value 9999 is the "follow the normal setting" sentinel in several fields
package contact_hold_pkg;

   // register bus geometry
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned SEL_W  = 3;

   // register indices on the plain parameter port
   localparam logic [3:0] ADDR_HOLD_ENABLE    = 4'h0;
   localparam logic [3:0] ADDR_LOW_PRESET     = 4'h1;
   localparam logic [3:0] ADDR_SECOND_STALL   = 4'h2;
   localparam logic [3:0] ADDR_NORMAL_STALL   = 4'h3;
   localparam logic [3:0] ADDR_EXCITE_FACTOR  = 4'h4;
   localparam logic [3:0] ADDR_HOLD_CARRIER   = 4'h5;
   localparam logic [3:0] ADDR_NORMAL_CARRIER = 4'h6;
   localparam logic [3:0] ADDR_REMOTE_SEL     = 4'h7;
   localparam logic [3:0] ADDR_OPMODE_SEL     = 4'h8;
   localparam logic [3:0] ADDR_PID_SEL        = 4'h9;
   localparam logic [3:0] ADDR_AUTO_ACCEL     = 4'ha;
   localparam logic [3:0] ADDR_CTRL_METHOD    = 4'hb;
   localparam logic [3:0] ADDR_STATUS         = 4'hc;
   localparam logic [3:0] ADDR_FREQ_APPLIED   = 4'hd;

   // sentinel and limits
   localparam logic [15:0] FOLLOW_NORMAL     = 16'h270f;  // 9999
   localparam logic [15:0] PRESET_MAX        = 16'h9c40;  // 400.00 Hz
   localparam logic [15:0] HOLD_FREQ_CLAMP   = 16'h0bb8;  // 30.00 Hz
   localparam logic [15:0] CARRIER_FREQ_EDGE = 16'h012c;  // 3.00 Hz
   localparam logic [15:0] STALL_MAX         = 16'h00c8;  // 200 %
   localparam logic [15:0] EXCITE_MAX        = 16'h012c;  // 300 %
   localparam logic [15:0] CARRIER_MAX       = 16'h0009;
   localparam logic [15:0] ENABLE_MAX        = 16'h0001;
   localparam logic [15:0] REMOTE_MAX        = 16'h0003;
   localparam logic [15:0] REMOTE_OFF        = 16'h0000;
   localparam logic [15:0] OPMODE_MAX        = 16'h0004;
   localparam logic [15:0] OPMODE_EXTERNAL   = 16'h0000;
   localparam logic [15:0] PID_OFF           = 16'h0000;
   localparam logic [15:0] AUTO_ACCEL_OFF    = 16'h0000;
   localparam logic [15:0] CTRL_VF           = 16'h0000;
   localparam logic [15:0] CTRL_ADVANCED     = 16'h0001;
   localparam logic [15:0] CTRL_GENERAL      = 16'h0002;

   // reset values
   localparam logic [15:0] RST_HOLD_ENABLE    = 16'h0000;
   localparam logic [15:0] RST_LOW_PRESET     = 16'h03e8;  // 10.00 Hz
   localparam logic [15:0] RST_SECOND_STALL   = FOLLOW_NORMAL;
   localparam logic [15:0] RST_NORMAL_STALL   = 16'h0096;  // 150 %
   localparam logic [15:0] RST_EXCITE_FACTOR  = FOLLOW_NORMAL;
   localparam logic [15:0] RST_HOLD_CARRIER   = FOLLOW_NORMAL;
   localparam logic [15:0] RST_NORMAL_CARRIER = 16'h0001;
   localparam logic [15:0] RST_ZERO           = 16'h0000;

   // status word bit positions
   localparam int unsigned STAT_HOLD_ACTIVE = 0;
   localparam int unsigned STAT_PERMITTED   = 1;
   localparam int unsigned STAT_LOW_SEL     = 2;
   localparam int unsigned STAT_SECOND_SEL  = 3;
   localparam int unsigned STAT_JOG         = 4;

   // synchronised select bundle bit positions
   localparam int unsigned SEL_LOW    = 0;
   localparam int unsigned SEL_SECOND = 1;
   localparam int unsigned SEL_JOG    = 2;

   typedef enum logic {
      MODE_NORMAL,
      MODE_HOLD
   } mode_e;

   // parameter set held by software
   typedef struct packed {
      logic [15:0] hold_enable;
      logic [15:0] low_speed_preset;
      logic [15:0] second_stall_level;
      logic [15:0] normal_stall_level;
      logic [15:0] holding_excitation_factor;
      logic [15:0] contact_hold_carrier;
      logic [15:0] normal_carrier_select;
      logic [15:0] remote_setting_select;
      logic [15:0] operation_mode_select;
      logic [15:0] pid_action_select;
      logic [15:0] auto_accel_select;
      logic [15:0] control_method;
   } param_regs_s;

   // drive settings handed to the motor control core
   typedef struct packed {
      logic [15:0] freq_cmd;
      logic [15:0] stall_level;
      logic        excite_comp_en;
      logic [15:0] excite_factor;
      logic [15:0] carrier_sel;
      logic        fast_limit_en;
      logic        hold_active;
   } drive_s;

   // speed command sources from the normal path
   typedef struct packed {
      logic        multi_speed_active;
      logic [15:0] multi_speed_freq;
      logic [15:0] analog_freq;
      logic [15:0] output_freq;
   } speed_src_s;

   typedef struct packed {
      logic [SEL_W-1:0] stage1;
      logic [SEL_W-1:0] stage2;
   } sync_state_s;

   typedef struct packed {
      param_regs_s regs;
      mode_e       mode;
      logic        permitted;
      drive_s      drive;
      logic [15:0] rd_data;
   } ctrl_state_s;

endpackage

// file: core/select_sync.sv
// Purpose: two-flop synchroniser for the terminal select inputs
// Assumes: inputs are quasi-static contact levels
// Notes:   stage1 feeds only stage2; nothing else samples it
`timescale 1ns/100ps
`default_nettype none
module select_sync
   import contact_hold_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [SEL_W-1:0] async_i,
   output logic      [SEL_W-1:0] sync_o
);

   sync_state_s st;
   sync_state_s next_st;

   // shift the raw levels through two stages
   always_comb begin
      next_st        = st;
      next_st.stage1 = async_i;
      next_st.stage2 = st.stage1;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_o = st.stage2;

endmodule
`default_nettype wire

// file: core/contact_hold_ctrl.sv
// Purpose: selects the contact-hold parameter set for the drive core
// Assumes: 100 MHz clk_i; frequency words in 0.01 Hz; levels in percent
// Notes:   every drive output is registered; mode follows the synced selects
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - enable word 0 gives normal running, 1 allows contact-hold; resets to 0.
// - enabled mode entered only while both low-speed and second-function selects active.
// - in the mode frequency comes from the low-speed preset, prior command ignored.
// - a preset above 30 Hz is limited to 30 Hz while holding.
// - low-speed preset takes 0 to 400 Hz, resets to 10 Hz.
// - stall level normal outside; second level (or normal at 9999) inside; no fast limit.
// - second stall level takes 0 to 200 percent or 9999; resets to 9999.
// - excitation factor takes 0 to 300 percent or 9999 meaning none; resets 9999.
// - excitation compensation applies only inside the mode, never in normal running.
// - inside mode at 3 Hz or below carrier uses hold carrier, else normal carrier.
// - hold carrier takes 0 to 9 or 9999 meaning follow normal; resets 9999.
// - outside the mode frequency is multi-speed preset or the analog input.
// - contact-hold works only in external operation with terminal control.
// - contact-hold needs advanced or general-purpose flux vector control.
// - panel, panel plus external, jog, PID, remote or auto-accel disable it.
// - remote setting selection of 1 to 3 disables contact-hold.
module contact_hold_ctrl
   import contact_hold_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // parameter port
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wr_data_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rd_data_o,
   // terminal inputs
   input  wire logic              low_speed_select_in_i,
   input  wire logic              second_function_select_in_i,
   input  wire logic              jog_select_in_i,
   // normal speed sources and output frequency feedback
   input  wire speed_src_s        speed_src_i,
   // settings to the drive core
   output drive_s                 drive_o
);

   ctrl_state_s      st;
   ctrl_state_s      next_st;
   logic [SEL_W-1:0] sel_raw;
   logic [SEL_W-1:0] sel_sync;
   logic             low_sel;
   logic             second_sel;
   logic             jog_sel;
   logic             permit;
   logic             enter_hold;
   logic             wr_ok;
   logic [15:0]      hold_freq;
   logic [15:0]      normal_freq;
   logic [15:0]      status_word;

   // contact levels cross into the clock domain first
   assign sel_raw[SEL_LOW]    = low_speed_select_in_i;
   assign sel_raw[SEL_SECOND] = second_function_select_in_i;
   assign sel_raw[SEL_JOG]    = jog_select_in_i;

   select_sync u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (sel_raw),
      .sync_o  (sel_sync)
   );

   assign low_sel    = sel_sync[SEL_LOW];
   assign second_sel = sel_sync[SEL_SECOND];
   assign jog_sel    = sel_sync[SEL_JOG];

   // gate conditions; any one of them vetoes the mode
   always_comb begin
      permit = (st.regs.hold_enable == ENABLE_MAX);
      if (st.regs.operation_mode_select != OPMODE_EXTERNAL) begin
         permit = 1'b0;
      end
      if ((st.regs.control_method != CTRL_ADVANCED) &&
          (st.regs.control_method != CTRL_GENERAL)) begin
         permit = 1'b0;
      end
      if (jog_sel) begin
         permit = 1'b0;
      end
      if (st.regs.pid_action_select != PID_OFF) begin
         permit = 1'b0;
      end
      if (st.regs.auto_accel_select != AUTO_ACCEL_OFF) begin
         permit = 1'b0;
      end
      if (st.regs.remote_setting_select != REMOTE_OFF) begin
         permit = 1'b0;
      end
   end

   // both selects needed; a drop of either leaves the mode next edge
   assign enter_hold = permit && low_sel && second_sel;

   // preset clamped so a mistyped preset cannot drive the stopper hard
   assign hold_freq = (st.regs.low_speed_preset > HOLD_FREQ_CLAMP) ?
                      HOLD_FREQ_CLAMP : st.regs.low_speed_preset;

   // normal command: multi-speed when a preset is picked, else analog
   assign normal_freq = speed_src_i.multi_speed_active ?
                        speed_src_i.multi_speed_freq : speed_src_i.analog_freq;

   // live status for software
   always_comb begin
      status_word                   = '0;
      status_word[STAT_HOLD_ACTIVE] = (st.mode == MODE_HOLD);
      status_word[STAT_PERMITTED]   = st.permitted;
      status_word[STAT_LOW_SEL]     = low_sel;
      status_word[STAT_SECOND_SEL]  = second_sel;
      status_word[STAT_JOG]         = jog_sel;
   end

   // range check per address; out-of-range writes keep the old value
   always_comb begin
      case (addr_i)
         ADDR_HOLD_ENABLE: begin
            wr_ok = (wr_data_i <= ENABLE_MAX);
         end
         ADDR_LOW_PRESET: begin
            wr_ok = (wr_data_i <= PRESET_MAX);
         end
         ADDR_SECOND_STALL: begin
            wr_ok = (wr_data_i <= STALL_MAX) || (wr_data_i == FOLLOW_NORMAL);
         end
         ADDR_NORMAL_STALL: begin
            wr_ok = (wr_data_i <= STALL_MAX);
         end
         ADDR_EXCITE_FACTOR: begin
            wr_ok = (wr_data_i <= EXCITE_MAX) || (wr_data_i == FOLLOW_NORMAL);
         end
         ADDR_HOLD_CARRIER: begin
            wr_ok = (wr_data_i <= CARRIER_MAX) || (wr_data_i == FOLLOW_NORMAL);
         end
         ADDR_NORMAL_CARRIER: begin
            wr_ok = (wr_data_i <= CARRIER_MAX);
         end
         ADDR_REMOTE_SEL: begin
            wr_ok = (wr_data_i <= REMOTE_MAX);
         end
         ADDR_OPMODE_SEL: begin
            wr_ok = (wr_data_i <= OPMODE_MAX);
         end
         ADDR_PID_SEL: begin
            wr_ok = 1'b1;
         end
         ADDR_AUTO_ACCEL: begin
            wr_ok = 1'b1;
         end
         ADDR_CTRL_METHOD: begin
            wr_ok = (wr_data_i <= CTRL_GENERAL);
         end
         default: begin
            wr_ok = 1'b0;  // status and unmapped words ignore writes
         end
      endcase
   end

   // next-state: register writes, read data, mode and drive settings
   always_comb begin
      next_st = st;

      if (wr_i && wr_ok) begin
         case (addr_i)
            ADDR_HOLD_ENABLE: begin
               next_st.regs.hold_enable = wr_data_i;
            end
            ADDR_LOW_PRESET: begin
               next_st.regs.low_speed_preset = wr_data_i;
            end
            ADDR_SECOND_STALL: begin
               next_st.regs.second_stall_level = wr_data_i;
            end
            ADDR_NORMAL_STALL: begin
               next_st.regs.normal_stall_level = wr_data_i;
            end
            ADDR_EXCITE_FACTOR: begin
               next_st.regs.holding_excitation_factor = wr_data_i;
            end
            ADDR_HOLD_CARRIER: begin
               next_st.regs.contact_hold_carrier = wr_data_i;
            end
            ADDR_NORMAL_CARRIER: begin
               next_st.regs.normal_carrier_select = wr_data_i;
            end
            ADDR_REMOTE_SEL: begin
               next_st.regs.remote_setting_select = wr_data_i;
            end
            ADDR_OPMODE_SEL: begin
               next_st.regs.operation_mode_select = wr_data_i;
            end
            ADDR_PID_SEL: begin
               next_st.regs.pid_action_select = wr_data_i;
            end
            ADDR_AUTO_ACCEL: begin
               next_st.regs.auto_accel_select = wr_data_i;
            end
            ADDR_CTRL_METHOD: begin
               next_st.regs.control_method = wr_data_i;
            end
            default: begin
               next_st.regs = st.regs;
            end
         endcase
      end

      // read data stands for one cycle only; unmapped reads give zero
      next_st.rd_data = '0;
      if (rd_i) begin
         case (addr_i)
            ADDR_HOLD_ENABLE:    next_st.rd_data = st.regs.hold_enable;
            ADDR_LOW_PRESET:     next_st.rd_data = st.regs.low_speed_preset;
            ADDR_SECOND_STALL:   next_st.rd_data = st.regs.second_stall_level;
            ADDR_NORMAL_STALL:   next_st.rd_data = st.regs.normal_stall_level;
            ADDR_EXCITE_FACTOR:  next_st.rd_data = st.regs.holding_excitation_factor;
            ADDR_HOLD_CARRIER:   next_st.rd_data = st.regs.contact_hold_carrier;
            ADDR_NORMAL_CARRIER: next_st.rd_data = st.regs.normal_carrier_select;
            ADDR_REMOTE_SEL:     next_st.rd_data = st.regs.remote_setting_select;
            ADDR_OPMODE_SEL:     next_st.rd_data = st.regs.operation_mode_select;
            ADDR_PID_SEL:        next_st.rd_data = st.regs.pid_action_select;
            ADDR_AUTO_ACCEL:     next_st.rd_data = st.regs.auto_accel_select;
            ADDR_CTRL_METHOD:    next_st.rd_data = st.regs.control_method;
            ADDR_STATUS:         next_st.rd_data = status_word;
            ADDR_FREQ_APPLIED:   next_st.rd_data = st.drive.freq_cmd;
            default:             next_st.rd_data = '0;
         endcase
      end

      // mode is re-evaluated every cycle from the synced selects
      next_st.permitted = permit;
      case (st.mode)
         MODE_NORMAL: begin
            if (enter_hold) begin
               next_st.mode = MODE_HOLD;
            end
         end
         MODE_HOLD: begin
            if (!enter_hold) begin
               next_st.mode = MODE_NORMAL;
            end
         end
         default: begin
            next_st.mode = MODE_NORMAL;
         end
      endcase

      // drive settings follow the decision made this cycle
      next_st.drive.carrier_sel = st.regs.normal_carrier_select;
      if (enter_hold) begin
         next_st.drive.hold_active   = 1'b1;
         next_st.drive.freq_cmd      = hold_freq;
         next_st.drive.fast_limit_en = 1'b0;
         next_st.drive.stall_level   =
            (st.regs.second_stall_level == FOLLOW_NORMAL) ?
            st.regs.normal_stall_level : st.regs.second_stall_level;
         // no compensation when the factor holds the sentinel
         next_st.drive.excite_comp_en =
            (st.regs.holding_excitation_factor != FOLLOW_NORMAL);
         next_st.drive.excite_factor  =
            (st.regs.holding_excitation_factor != FOLLOW_NORMAL) ?
            st.regs.holding_excitation_factor : RST_ZERO;
         if ((speed_src_i.output_freq <= CARRIER_FREQ_EDGE) &&
             (st.regs.contact_hold_carrier != FOLLOW_NORMAL)) begin
            next_st.drive.carrier_sel = st.regs.contact_hold_carrier;
         end
      end else begin
         next_st.drive.hold_active    = 1'b0;
         next_st.drive.freq_cmd       = normal_freq;
         next_st.drive.fast_limit_en  = 1'b1;
         next_st.drive.stall_level    = st.regs.normal_stall_level;
         next_st.drive.excite_comp_en = 1'b0;
         next_st.drive.excite_factor  = RST_ZERO;
      end
   end

   // single state register; reset loads constants only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st.regs.hold_enable               <= RST_HOLD_ENABLE;
         st.regs.low_speed_preset          <= RST_LOW_PRESET;
         st.regs.second_stall_level        <= RST_SECOND_STALL;
         st.regs.normal_stall_level        <= RST_NORMAL_STALL;
         st.regs.holding_excitation_factor <= RST_EXCITE_FACTOR;
         st.regs.contact_hold_carrier      <= RST_HOLD_CARRIER;
         st.regs.normal_carrier_select     <= RST_NORMAL_CARRIER;
         st.regs.remote_setting_select     <= RST_ZERO;
         st.regs.operation_mode_select     <= OPMODE_EXTERNAL;
         st.regs.pid_action_select         <= RST_ZERO;
         st.regs.auto_accel_select         <= RST_ZERO;
         st.regs.control_method            <= CTRL_VF;
         st.mode                           <= MODE_NORMAL;
         st.permitted                      <= 1'b0;
         st.drive.freq_cmd                 <= RST_ZERO;
         st.drive.stall_level              <= RST_NORMAL_STALL;
         st.drive.excite_comp_en           <= 1'b0;
         st.drive.excite_factor            <= RST_ZERO;
         st.drive.carrier_sel              <= RST_NORMAL_CARRIER;
         st.drive.fast_limit_en            <= 1'b1;
         st.drive.hold_active              <= 1'b0;
         st.rd_data                        <= RST_ZERO;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data_o = st.rd_data;
   assign drive_o   = st.drive;

endmodule
`default_nettype wire

// file: test/contact_hold_ctrl_monitor.sv
// Purpose: concurrent checks on the contact-hold control ports
// Assumes: three-edge select latency, one-edge speed source latency
// Notes:   watches design inputs and outputs; bound at the foot of the file
`timescale 1ns/100ps
`default_nettype none
module contact_hold_ctrl_monitor
   import contact_hold_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wr_data_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic [DATA_W-1:0] rd_data_o,
   input  wire logic              low_speed_select_in_i,
   input  wire logic              second_function_select_in_i,
   input  wire logic              jog_select_in_i,
   input  wire speed_src_s        speed_src_i,
   input  wire drive_s            drive_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   speed_src_s src_q;
   // speed source seen one edge late, as the drive register sees it
   always_ff @(posedge clk_i) begin
      src_q <= speed_src_i;
   end
   a_read_quiet: assert property (!rd_i |=> rd_data_o == 16'h0)
      else $error("read data not idle");
   a_hold_both_sel: assert property (drive_o.hold_active |->
      $past(low_speed_select_in_i, 3) && $past(second_function_select_in_i, 3))
      else $error("hold without both selects");
   a_leave_fast: assert property (!(low_speed_select_in_i &&
      second_function_select_in_i) |-> ##3 !drive_o.hold_active)
      else $error("hold kept after select dropped");
   a_jog_veto: assert property (jog_select_in_i |-> ##3 !drive_o.hold_active)
      else $error("hold during jog");
   a_fast_lim: assert property (drive_o.fast_limit_en == !drive_o.hold_active)
      else $error("fast limit state wrong");
   a_comp_in_hold: assert property (drive_o.excite_comp_en |->
      drive_o.hold_active && drive_o.excite_factor != 16'h270f)
      else $error("compensation outside hold");
   a_freq_clamp: assert property (drive_o.hold_active |-> drive_o.freq_cmd <= 16'h0bb8)
      else $error("hold frequency above clamp");
   a_normal_freq: assert property (!drive_o.hold_active |-> drive_o.freq_cmd ==
      (src_q.multi_speed_active ? src_q.multi_speed_freq : src_q.analog_freq))
      else $error("normal frequency source wrong");
   c_hold: cover property ($rose(drive_o.hold_active));
   c_comp: cover property (drive_o.excite_comp_en);
   c_read: cover property (rd_i ##1 rd_data_o != 16'h0);
endmodule
bind contact_hold_ctrl contact_hold_ctrl_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
   .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
   .low_speed_select_in_i(low_speed_select_in_i), .jog_select_in_i(jog_select_in_i),
   .second_function_select_in_i(second_function_select_in_i),
   .speed_src_i(speed_src_i), .drive_o(drive_o));
`default_nettype wire

// file: test/contact_master.sv
// Purpose: machine controller driving the terminal contacts
// Assumes: want_i is {jog, second function, low speed}
// Notes:   a slow relay updates only every fourth edge, up to four edges late, testing the synchroniser
`timescale 1ns/100ps
`default_nettype none
module contact_master (
   input  wire logic       clk_i,
   input  wire logic [2:0] want_i,
   input  wire logic       slow_i,
   output logic      [2:0] sel_o
);
   logic [1:0] lag;
   initial begin
      sel_o = 3'h0;
      lag   = 2'h0;
   end
   // second function comes from a terminal given code 3
   always @(posedge clk_i) begin
      if (!slow_i || lag == 2'h3) begin
         sel_o <= want_i;
         lag   <= 2'h0;
      end else begin
         lag <= lag + 2'h1;
      end
   end
endmodule
`default_nettype wire

// file: test/contact_hold_ctrl_tb.sv
// Purpose: self-checking bench for the contact-hold control
// Assumes: regs in range are mirrored in m; selects settle in 8 edges
// Notes:   random values from a seeded xorshift, corners among them
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin miscompares++; \
   $display("[ERR] %0t got %h want %h", $time, g, x); end end
module contact_hold_ctrl_tb
   import contact_hold_pkg::*;
;
   localparam logic [15:0] RST_V [12] = '{16'h0, 16'h3e8, 16'h270f, 16'h96, 16'h270f,
      16'h270f, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
   localparam logic [15:0] BAD_D [9] = '{16'h2, 16'h9c41, 16'hc9, 16'hc9, 16'h12d,
      16'ha, 16'ha, 16'h4, 16'h5};
   localparam logic [3:0]  VETO_A [8] = '{4'h8, 4'h8, 4'hb, 4'h9, 4'ha, 4'h7, 4'h7, 4'h0};
   localparam logic [15:0] VETO_D [8] = '{16'h1, 16'h3, 16'h0, 16'h1, 16'h1, 16'h1, 16'h3,
      16'h0};
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [3:0]  addr  = 4'h0;
   logic [15:0] wdat  = 16'h0;
   logic        wr_s  = 1'b0;
   logic        rd_s  = 1'b0;
   logic [15:0] rd_data;
   logic [2:0]  want  = 3'h0;
   logic        slow  = 1'b0;
   logic [2:0]  sel;
   speed_src_s  src   = '0;
   drive_s      drv;
   logic [15:0] m [12];
   logic [31:0] seed  = 32'h000169bf;
   int          miscompares = 0;
   int          cmp_count   = 0;
   always #5 clk_i = ~clk_i;
   contact_master u_far (.clk_i(clk_i), .want_i(want), .slow_i(slow), .sel_o(sel));
   contact_hold_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wr_data_i(wdat),
      .wr_i(wr_s), .rd_i(rd_s), .rd_data_o(rd_data), .low_speed_select_in_i(sel[0]),
      .second_function_select_in_i(sel[1]), .jog_select_in_i(sel[2]), .speed_src_i(src),
      .drive_o(drv));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // a quarter of draws give the follow-normal sentinel
   function automatic logic [15:0] pick(input logic [31:0] lim);
      logic [31:0] r;
      r = rnd();
      return r[1:0] == 2'h0 ? 16'h270f : 16'(r % lim);
   endfunction
   // every gate of the mode except the two selects themselves
   function automatic logic allowed();
      return m[0] == 16'h1 && m[8] == 16'h0 && (m[11] == 16'h1 || m[11] == 16'h2) && !want[2]
         && m[9] == 16'h0 && m[10] == 16'h0 && m[7] == 16'h0;
   endfunction
   function automatic drive_s predict();
      drive_s d;
      logic   h;
      h = allowed() && want[1:0] == 2'h3;
      d.hold_active    = h;
      d.fast_limit_en  = !h;
      d.freq_cmd       = h ? (m[1] > 16'h0bb8 ? 16'h0bb8 : m[1])
         : (src.multi_speed_active ? src.multi_speed_freq : src.analog_freq);
      d.stall_level    = (h && m[2] != 16'h270f) ? m[2] : m[3];
      d.excite_comp_en = h && m[4] != 16'h270f;
      d.excite_factor  = d.excite_comp_en ? m[4] : 16'h0;
      d.carrier_sel    = (h && src.output_freq <= 16'h12c && m[5] != 16'h270f) ? m[5] : m[6];
      return d;
   endfunction
   // strobe left high on return; a later rd or settle drops it, a next wr keeps it high
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic keep);
      addr <= a;
      wdat <= d;
      rd_s <= 1'b0;
      wr_s <= 1'b1;
      @(posedge clk_i);
      if (keep) m[a] = d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] q);
      addr <= a;
      wr_s <= 1'b0;
      rd_s <= 1'b1;
      @(posedge clk_i);
      rd_s <= 1'b0;
      // data stand only in the cycle after the strobe; taken mid-cycle
      @(negedge clk_i);
      q = rd_data;
      @(posedge clk_i);
   endtask
   task automatic settle();
      wr_s <= 1'b0;
      rd_s <= 1'b0;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      `CHK(drv, predict())
      @(posedge clk_i);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // cut a hang short well past the expected thousand or so cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      logic [15:0] q;
      logic [31:0] r;
      logic [15:0] old;
      drive_s      e;
      m = RST_V;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, then status, applied freq and unmapped read as zero
      for (int i = 0; i < 16; i++) begin
         rd(i[3:0], q);
         `CHK(q, i < 12 ? m[i] : 16'h0)
      end
      $display("test reset done");
      for (int i = 0; i < 9; i++) begin
         wr(i[3:0], BAD_D[i], 1'b0);
         rd(i[3:0], q);
         `CHK(q, m[i])
      end
      $display("test range done");
      for (int n = 0; n < 40; n++) begin
         wr(4'h0, 16'h1, 1'b1);
         wr(4'hb, 16'h1 + 16'(rnd() % 32'h2), 1'b1);
         wr(4'h1, 16'(rnd() % 32'h9c41), 1'b1);
         wr(4'h2, pick(32'hc9), 1'b1);
         wr(4'h4, pick(32'h12d), 1'b1);
         wr(4'h5, pick(32'ha), 1'b1);
         wr(4'h6, 16'(rnd() % 32'ha), 1'b1);
         r = rnd();
         src  <= {1'(rnd()), 32'(rnd()), 16'h12a + 16'(rnd() % 32'h5)};
         want <= {r[2] & r[3], r[1:0] | {2{r[4]}}};
         slow <= r[5];
         settle();
         e = predict();
         rd(4'hd, q);
         `CHK(q, e.freq_cmd)
         rd(4'hc, q);
         `CHK(q, {11'h0, want, allowed(), allowed() && want == 3'h3})
      end
      $display("test random done");
      // clamp corner just above the limit, then each disabling condition
      wr(4'h1, 16'h0bb9, 1'b1);
      want <= 3'h3;
      settle();
      for (int i = 0; i < 8; i++) begin
         old = m[VETO_A[i]];
         wr(VETO_A[i], VETO_D[i], 1'b1);
         settle();
         wr(VETO_A[i], old, 1'b1);
      end
      want <= 3'h7;
      settle();
      $display("test veto done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
